// ---- logic/uff_pkg.sv ----
`default_nettype none
package uff_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BAUD_BPS = 9600;
  localparam int unsigned FRAME_BITS = 10;
  // Least low time of one frame, rounded up to whole clock cycles.
  localparam int unsigned BREAK_CYCLES = (CLK_HZ * FRAME_BITS + BAUD_BPS - 1) / BAUD_BPS;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_FULL = 5'h10;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_TXDATA = 8'h04;
  localparam logic [7:0] OFS_RXDATA = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_IRQ_ST = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN = 8'h1C;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BIT_TRANSMIT_END_FLAG = 6;
  localparam int unsigned BIT_TX_FIFO_EMPTY_FLAG = 5;
  localparam int unsigned BIT_BRK = 4;
  localparam int unsigned BIT_FER = 3;
  localparam int unsigned BIT_PER = 2;
  localparam int unsigned BIT_RDF = 1;
  localparam logic [15:0] STATUS_RST = 16'h0060;
  localparam int unsigned CTL_TE = 0;
  localparam int unsigned CTL_TTRG = 4;
  localparam int unsigned CTL_RTRG = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int unsigned CNT_TX = 8;
  localparam int unsigned CNT_RX = 0;
  localparam int unsigned IRQ_TRANSMIT_END_FLAG = 0;
  localparam int unsigned IRQ_TX_FIFO_EMPTY_FLAG = 1;
  localparam int unsigned IRQ_BRK = 2;
  localparam int unsigned IRQ_RDF = 3;
  localparam logic [3:0] IRQ_RST = 4'h0;

  // Trigger numbers per two-bit select code.
  localparam logic [4:0] TX_TRIG_0 = 5'h08;
  localparam logic [4:0] TX_TRIG_1 = 5'h04;
  localparam logic [4:0] TX_TRIG_2 = 5'h02;
  localparam logic [4:0] TX_TRIG_3 = 5'h00;
  localparam logic [4:0] RX_TRIG_0 = 5'h01;
  localparam logic [4:0] RX_TRIG_1 = 5'h04;
  localparam logic [4:0] RX_TRIG_2 = 5'h08;
  localparam logic [4:0] RX_TRIG_3 = 5'h0E;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic head_framing_error;
    logic head_parity_error;
    logic [7:0] data;
  } uff_rx_entry_t;
endpackage : uff_pkg
`default_nettype wire

// ---- logic/uff_top.sv ----
// Functional notes
// (R1) Zero write after read-one clears transmit end once the transmit FIFO holds data.
// (R2) A DMA write into the transmit FIFO clears transmit end.
// (R3) Transmit end stays one while the transmitter is disabled.
// (R4) Transmit end sets after a character's last bit with the transmit FIFO empty.
// (R5) Transmit empty sets when a pop leaves the count at or below trigger.
// (R6) Transmit empty clears when count exceeds trigger, by software sequence or DMA.
// (R7) Transmit FIFO holds sixteen bytes; writes beyond the room are dropped.
// (R8) The count register shows the transmit FIFO byte count in its upper field.
// (R9) Break sets after a framing-error character and one frame of low line.
// (R10) Break clears only on reset or a zero write after read-one.
// (R11) During a break all-zero characters are not stored until the line is mark.
// (R12) Framing indicator follows the head entry of the receive FIFO.
// (R13) Parity indicator follows the head entry of the receive FIFO.
// (R14) Receive full sets when a push brings the count to trigger or more.
// (R15) Reset sets transmit end and empty, clears break, framing and parity.
// (R16) Writing one to a clearable flag is ignored; zero clears it.
// (R17) A zero write clears only a flag previously read as one.
// (R18) Head indicators are refreshed whenever the receive head advances.
`timescale 1ns/1ps
`default_nettype none
module uff_top #(
  parameter int unsigned P_BREAK_CYCLES = uff_pkg::BREAK_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_tx_take,
  input wire logic i_tx_last_bit,
  output logic o_tx_avail,
  output logic [7:0] o_tx_byte,
  input wire logic i_rx_valid,
  input wire uff_pkg::uff_rx_entry_t i_rx_entry,
  input wire logic i_rx_pin,
  input wire logic i_dma_tx_wr,
  input wire logic [7:0] i_dma_tx_data,
  input wire logic i_dma_rx_rd,
  output logic [7:0] o_dma_rx_data,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic aw_hs, w_hs, wr_go, rd_go, nxt_aw_held, nxt_w_held, nxt_rvalid;
  logic wr_ok, rd_ok;
  logic [31:0] rd_mux;

  assign aw_hs = i_awvalid & awready_ff;
  assign w_hs = i_wvalid & wready_ff;
  assign wr_go = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign rd_go = i_arvalid & arready_ff;
  assign nxt_aw_held = aw_hs | (aw_held_ff & ~wr_go);
  assign nxt_w_held = w_hs | (w_held_ff & ~wr_go);
  assign nxt_rvalid = rd_go | (rvalid_ff & ~i_rready);

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= uff_pkg::RESP_OKAY;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      awready_ff <= ~nxt_aw_held;
      wready_ff <= ~nxt_w_held;
      if (aw_hs) begin
        awaddr_ff <= i_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= i_wdata;
        wstrb_ff <= i_wstrb;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? uff_pkg::RESP_OKAY : uff_pkg::RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= uff_pkg::RESP_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (rd_go) begin
        rdata_ff <= rd_ok ? rd_mux : 32'h0000_0000;
        rresp_ff <= rd_ok ? uff_pkg::RESP_OKAY : uff_pkg::RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags, FIFOs and registers
  // ----------------------------------------------------------------
  logic transmit_end_flag_ff, tx_fifo_empty_flag_ff, brk_ff, rdf_ff, fer_ff, per_ff;
  logic arm_transmit_end_flag_ff, arm_tx_fifo_empty_flag_ff, arm_brk_ff, arm_rdf_ff;
  logic [7:0] ctrl_ff;
  logic [3:0] irq_st_ff, irq_en_ff, irq_ev;
  logic irq_ff;
  logic [7:0] tx_mem_ff [uff_pkg::FIFO_DEPTH];
  uff_pkg::uff_rx_entry_t rx_mem_ff [uff_pkg::FIFO_DEPTH];
  logic [3:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
  logic [4:0] tx_cnt_ff, rx_cnt_ff, nxt_tx_cnt, nxt_rx_cnt, tx_trig, rx_trig;
  logic tx_avail_ff;
  logic [7:0] tx_byte_ff, dma_rx_ff;
  logic [15:0] status_rd;
  logic sel_st_w, st_wr, z_transmit_end_flag, z_tx_fifo_empty_flag, z_brk, z_rdf, st_rd;
  logic sw_tx_wr, tx_push, dma_tx_ok, tx_pop, rx_push, sw_rx_rd, dma_rx_pop, rx_pop;
  logic [7:0] tx_push_data;
  logic transmit_end_flag_set, transmit_end_flag_clr, tx_fifo_empty_flag_set, tx_fifo_empty_flag_clr, rdf_set, rdf_clr, brk_set;
  logic rx_s1_ff, rx_s2_ff, rx_s3_ff, rx_line_ff, fer_seen_ff, brk_act_ff;
  logic [19:0] low_cnt_ff;

  always_comb begin
    unique case (ctrl_ff[uff_pkg::CTL_TTRG +: 2])
      2'h0: tx_trig = uff_pkg::TX_TRIG_0;
      2'h1: tx_trig = uff_pkg::TX_TRIG_1;
      2'h2: tx_trig = uff_pkg::TX_TRIG_2;
      2'h3: tx_trig = uff_pkg::TX_TRIG_3;
    endcase
    unique case (ctrl_ff[uff_pkg::CTL_RTRG +: 2])
      2'h0: rx_trig = uff_pkg::RX_TRIG_0;
      2'h1: rx_trig = uff_pkg::RX_TRIG_1;
      2'h2: rx_trig = uff_pkg::RX_TRIG_2;
      2'h3: rx_trig = uff_pkg::RX_TRIG_3;
    endcase
  end

  always_comb begin
    status_rd = 16'h0000;
    status_rd[uff_pkg::BIT_TRANSMIT_END_FLAG] = transmit_end_flag_ff;
    status_rd[uff_pkg::BIT_TX_FIFO_EMPTY_FLAG] = tx_fifo_empty_flag_ff;
    status_rd[uff_pkg::BIT_BRK] = brk_ff;
    status_rd[uff_pkg::BIT_FER] = fer_ff;
    status_rd[uff_pkg::BIT_PER] = per_ff;
    status_rd[uff_pkg::BIT_RDF] = rdf_ff;
    rd_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (i_araddr)
      uff_pkg::OFS_STATUS: rd_mux[15:0] = status_rd;
      uff_pkg::OFS_RXDATA: rd_mux[7:0] = rx_mem_ff[rx_rp_ff].data;
      // (R8) Transmit count field.
      uff_pkg::OFS_COUNT: begin
        rd_mux[uff_pkg::CNT_TX +: 5] = tx_cnt_ff;
        rd_mux[uff_pkg::CNT_RX +: 5] = rx_cnt_ff;
      end
      uff_pkg::OFS_CTRL: rd_mux[7:0] = ctrl_ff;
      uff_pkg::OFS_IRQ_ST: rd_mux[3:0] = irq_st_ff;
      uff_pkg::OFS_IRQ_EN: rd_mux[3:0] = irq_en_ff;
      uff_pkg::OFS_TXDATA, uff_pkg::OFS_IRQ_CLR: rd_mux = 32'h0000_0000;
      default: rd_ok = 1'b0;
    endcase
    wr_ok = 1'b1;
    unique case (awaddr_ff)
      uff_pkg::OFS_STATUS, uff_pkg::OFS_TXDATA, uff_pkg::OFS_CTRL: wr_ok = 1'b1;
      uff_pkg::OFS_IRQ_CLR, uff_pkg::OFS_IRQ_EN, uff_pkg::OFS_RXDATA: wr_ok = 1'b1;
      uff_pkg::OFS_COUNT, uff_pkg::OFS_IRQ_ST: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Decoded accesses; all write effects need byte lane 0.
  assign sel_st_w = wr_go & wstrb_ff[0] & (awaddr_ff == uff_pkg::OFS_STATUS);
  assign st_wr = sel_st_w;
  // (R16) Only zero clears.
  assign z_transmit_end_flag = sel_st_w & ~wdata_ff[uff_pkg::BIT_TRANSMIT_END_FLAG] & arm_transmit_end_flag_ff;
  assign z_tx_fifo_empty_flag = sel_st_w & ~wdata_ff[uff_pkg::BIT_TX_FIFO_EMPTY_FLAG] & arm_tx_fifo_empty_flag_ff;
  assign z_brk = sel_st_w & ~wdata_ff[uff_pkg::BIT_BRK] & arm_brk_ff;
  assign z_rdf = sel_st_w & ~wdata_ff[uff_pkg::BIT_RDF] & arm_rdf_ff;
  assign st_rd = rd_go & (i_araddr == uff_pkg::OFS_STATUS);
  assign sw_tx_wr = wr_go & wstrb_ff[0] & (awaddr_ff == uff_pkg::OFS_TXDATA);
  assign sw_rx_rd = rd_go & (i_araddr == uff_pkg::OFS_RXDATA);

  // (R7) Drop writes beyond room.
  assign tx_push = (sw_tx_wr | i_dma_tx_wr) & (tx_cnt_ff != uff_pkg::FIFO_FULL);
  assign dma_tx_ok = tx_push & ~sw_tx_wr;
  assign tx_push_data = sw_tx_wr ? wdata_ff[7:0] : i_dma_tx_data;
  assign tx_pop = i_tx_take & (tx_cnt_ff != 5'h00);
  assign nxt_tx_cnt = tx_cnt_ff + {4'h0, tx_push} - {4'h0, tx_pop};

  // (R11) Drop break zeros.
  assign rx_push = i_rx_valid & (rx_cnt_ff != uff_pkg::FIFO_FULL)
      & ~(brk_act_ff & (i_rx_entry.data == 8'h00));
  assign dma_rx_pop = i_dma_rx_rd & ~sw_rx_rd & (rx_cnt_ff != 5'h00);
  assign rx_pop = (sw_rx_rd & (rx_cnt_ff != 5'h00)) | dma_rx_pop;
  assign nxt_rx_cnt = rx_cnt_ff + {4'h0, rx_push} - {4'h0, rx_pop};

  // (R3) Disabled holds one.
  // (R4) Last bit, empty.
  assign transmit_end_flag_set = ~ctrl_ff[uff_pkg::CTL_TE] | (i_tx_last_bit & (nxt_tx_cnt == 5'h00));
  // (R1) Software clear sequence.
  // (R2) DMA write clears.
  assign transmit_end_flag_clr = (z_transmit_end_flag & (tx_cnt_ff != 5'h00)) | dma_tx_ok;
  // (R5) Pop to trigger.
  assign tx_fifo_empty_flag_set = tx_pop & (nxt_tx_cnt <= tx_trig);
  // (R6) Above trigger clears.
  assign tx_fifo_empty_flag_clr = (z_tx_fifo_empty_flag | dma_tx_ok) & (nxt_tx_cnt > tx_trig);
  // (R14) Push reaches trigger.
  assign rdf_set = rx_push & (nxt_rx_cnt >= rx_trig);
  assign rdf_clr = (z_rdf | dma_rx_pop) & (nxt_rx_cnt < rx_trig);

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // (R15) Reset values.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      transmit_end_flag_ff <= uff_pkg::STATUS_RST[uff_pkg::BIT_TRANSMIT_END_FLAG];
      tx_fifo_empty_flag_ff <= uff_pkg::STATUS_RST[uff_pkg::BIT_TX_FIFO_EMPTY_FLAG];
      brk_ff <= uff_pkg::STATUS_RST[uff_pkg::BIT_BRK];
      rdf_ff <= uff_pkg::STATUS_RST[uff_pkg::BIT_RDF];
    end else begin
      // Every set outranks a clear in the same cycle.
      transmit_end_flag_ff <= transmit_end_flag_set | (transmit_end_flag_ff & ~transmit_end_flag_clr);
      tx_fifo_empty_flag_ff <= tx_fifo_empty_flag_set | (tx_fifo_empty_flag_ff & ~tx_fifo_empty_flag_clr);
      // (R10) Break clear.
      brk_ff <= brk_set | (brk_ff & ~z_brk);
      rdf_ff <= rdf_set | (rdf_ff & ~rdf_clr);
    end
  end

  // (R17) Arm on read-one.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      arm_transmit_end_flag_ff <= 1'b0;
      arm_tx_fifo_empty_flag_ff <= 1'b0;
      arm_brk_ff <= 1'b0;
      arm_rdf_ff <= 1'b0;
    end else begin
      arm_transmit_end_flag_ff <= (st_rd & transmit_end_flag_ff) | (arm_transmit_end_flag_ff & ~st_wr);
      arm_tx_fifo_empty_flag_ff <= (st_rd & tx_fifo_empty_flag_ff) | (arm_tx_fifo_empty_flag_ff & ~st_wr);
      arm_brk_ff <= (st_rd & brk_ff) | (arm_brk_ff & ~st_wr);
      arm_rdf_ff <= (st_rd & rdf_ff) | (arm_rdf_ff & ~st_wr);
    end
  end

  // ----------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_wp_ff <= 4'h0;
      tx_rp_ff <= 4'h0;
      tx_cnt_ff <= 5'h00;
      tx_avail_ff <= 1'b0;
      tx_byte_ff <= 8'h00;
    end else begin
      tx_cnt_ff <= nxt_tx_cnt;
      tx_avail_ff <= (nxt_tx_cnt != 5'h00);
      if (tx_push) begin
        tx_wp_ff <= tx_wp_ff + 4'h1;
      end
      if (tx_pop) begin
        tx_rp_ff <= tx_rp_ff + 4'h1;
        tx_byte_ff <= tx_mem_ff[tx_rp_ff];
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive FIFO and head indicators
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_wp_ff <= 4'h0;
      rx_rp_ff <= 4'h0;
      rx_cnt_ff <= 5'h00;
      dma_rx_ff <= 8'h00;
      fer_ff <= uff_pkg::STATUS_RST[uff_pkg::BIT_FER];
      per_ff <= uff_pkg::STATUS_RST[uff_pkg::BIT_PER];
    end else begin
      rx_cnt_ff <= nxt_rx_cnt;
      if (rx_push) begin
        rx_wp_ff <= rx_wp_ff + 4'h1;
      end
      if (rx_pop) begin
        rx_rp_ff <= rx_rp_ff + 4'h1;
      end
      if (dma_rx_pop) begin
        dma_rx_ff <= rx_mem_ff[rx_rp_ff].data;
      end
      // (R12) Head framing.
      // (R13) Head parity.
      // (R18) Refreshed each cycle.
      fer_ff <= (rx_cnt_ff != 5'h00) & rx_mem_ff[rx_rp_ff].head_framing_error;
      per_ff <= (rx_cnt_ff != 5'h00) & rx_mem_ff[rx_rp_ff].head_parity_error;
    end
  end

  // Storage has no reset; the counts guard every read except the RXDATA register read.
  genvar gi;
  generate
    for (gi = 0; gi < uff_pkg::FIFO_DEPTH; gi++) begin : g_mem
      always_ff @(posedge i_sys_clk) begin
        if (tx_push && tx_wp_ff == 4'(gi)) begin
          tx_mem_ff[gi] <= tx_push_data;
        end
        if (rx_push && rx_wp_ff == 4'(gi)) begin
          rx_mem_ff[gi] <= i_rx_entry;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Break detection
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_s3_ff <= 1'b1;
      rx_line_ff <= 1'b1;
    end else begin
      rx_s1_ff <= i_rx_pin;
      rx_s2_ff <= rx_s1_ff;
      rx_s3_ff <= rx_s2_ff;
      if (rx_s2_ff == rx_s3_ff) begin
        rx_line_ff <= rx_s3_ff;
      end
    end
  end

  // (R9) Framing error, frame low.
  assign brk_set = fer_seen_ff & ~rx_line_ff & ~brk_act_ff
      & (low_cnt_ff == 20'(P_BREAK_CYCLES - 1));

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fer_seen_ff <= 1'b0;
      brk_act_ff <= 1'b0;
      low_cnt_ff <= 20'h0_0000;
    end else begin
      if (rx_line_ff) begin
        fer_seen_ff <= 1'b0;
        brk_act_ff <= 1'b0;
        low_cnt_ff <= 20'h0_0000;
      end else begin
        if (i_rx_valid && i_rx_entry.head_framing_error) begin
          fer_seen_ff <= 1'b1;
        end
        if (brk_set) begin
          brk_act_ff <= 1'b1;
        end
        if (fer_seen_ff && !brk_act_ff) begin
          low_cnt_ff <= low_cnt_ff + 20'h0_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and interrupts
  // ----------------------------------------------------------------
  assign irq_ev = {rdf_set, brk_set, tx_fifo_empty_flag_set, transmit_end_flag_set & ~transmit_end_flag_ff};

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_ff <= uff_pkg::CTRL_RST;
      irq_en_ff <= uff_pkg::IRQ_RST;
      irq_st_ff <= uff_pkg::IRQ_RST;
      irq_ff <= 1'b0;
    end else begin
      if (wr_go && wstrb_ff[0] && awaddr_ff == uff_pkg::OFS_CTRL) begin
        ctrl_ff <= wdata_ff[7:0];
      end
      if (wr_go && wstrb_ff[0] && awaddr_ff == uff_pkg::OFS_IRQ_EN) begin
        irq_en_ff <= wdata_ff[3:0];
      end
      if (wr_go && wstrb_ff[0] && awaddr_ff == uff_pkg::OFS_IRQ_CLR) begin
        irq_st_ff <= (irq_st_ff & ~wdata_ff[3:0]) | irq_ev;
      end else begin
        irq_st_ff <= irq_st_ff | irq_ev;
      end
      irq_ff <= |(irq_st_ff & irq_en_ff);
    end
  end

  assign o_awready = awready_ff;
  assign o_wready = wready_ff;
  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;
  assign o_arready = arready_ff;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;
  assign o_tx_avail = tx_avail_ff;
  assign o_tx_byte = tx_byte_ff;
  assign o_dma_rx_data = dma_rx_ff;
  assign o_irq = irq_ff;

endmodule : uff_top
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_sys_clk = 1'h0;
  logic i_reset_n = 1'h0;
  logic [7:0] i_awaddr = 8'h00;
  logic [7:0] i_araddr = 8'h00;
  logic [7:0] i_dma_tx_data = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [3:0] i_wstrb = 4'hF;
  logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0;
  logic i_rready = 1'h0, i_dma_tx_wr = 1'h0, i_dma_rx_rd = 1'h0;
  logic i_tx_take, i_tx_last_bit, i_rx_valid, i_rx_pin;
  uff_pkg::uff_rx_entry_t i_rx_entry;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_tx_avail, o_irq;
  logic [1:0] o_bresp, o_rresp, rr;
  logic [31:0] o_rdata, rv;
  logic [7:0] o_tx_byte, o_dma_rx_data;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  always #50 i_sys_clk = ~i_sys_clk;
  uff_top #(.P_BREAK_CYCLES(20)) i_uff_top (.*);
  uff_line_model i_uff_line_model (.i_sys_clk(i_sys_clk), .i_tx_avail(o_tx_avail),
    .o_tx_take(i_tx_take), .o_last_bit(i_tx_last_bit), .o_rx_valid(i_rx_valid),
    .o_rx_entry(i_rx_entry), .o_rx_pin(i_rx_pin));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do begin
      @(posedge i_sys_clk);
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
    end while (o_bvalid !== 1'h1);
    i_bready <= 1'h0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_sys_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do begin
      @(posedge i_sys_clk);
      if (o_arready) i_arvalid <= 1'h0;
      rv = o_rdata;
      rr = o_rresp;
    end while (o_rvalid !== 1'h1);
    i_rready <= 1'h0;
    chk(rv, exp);
  endtask : rdc
  task automatic dma_push(input int cnt, input logic [7:0] base);
    for (int k = 0; k < cnt; k++) begin
      @(posedge i_sys_clk);
      i_dma_tx_wr <= 1'h1;
      i_dma_tx_data <= base + 8'(k);
      @(posedge i_sys_clk);
      i_dma_tx_wr <= 1'h0;
    end
  endtask : dma_push
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("MISMATCH t=%0t run did not finish", $time);
      print_verdict();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_reset_n <= 1'h1;
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0060);
    rdc(uff_pkg::OFS_COUNT, 32'h0000_0000);
    rdc(8'h20, 32'h0000_0000);
    chk({30'h0000_0000, rr}, {30'h0000_0000, uff_pkg::RESP_SLVERR});
    wr(uff_pkg::OFS_STATUS, 32'h0000_FFFF);
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0060);
    wr(uff_pkg::OFS_TXDATA, 32'h0000_00A5);
    wr(uff_pkg::OFS_STATUS, 32'h0000_0000);
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0060);
    wr(uff_pkg::OFS_CTRL, 32'h0000_0001);
    wr(uff_pkg::OFS_STATUS, 32'h0000_0000);
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0020);
    $display("test register access done");
    i_uff_line_model.take(1);
    #1 chk({24'h00_0000, o_tx_byte}, 32'h0000_00A5);
    i_uff_line_model.last_bit();
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0060);
    dma_push(9, 8'h10);
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0000);
    rdc(uff_pkg::OFS_COUNT, 32'h0000_0900);
    dma_push(9, 8'h40);
    rdc(uff_pkg::OFS_COUNT, 32'h0000_1000);
    i_uff_line_model.take(1);
    #1 chk({24'h00_0000, o_tx_byte}, 32'h0000_0010);
    i_uff_line_model.take(7);
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0020);
    i_uff_line_model.take(8);
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0020);
    i_uff_line_model.last_bit();
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0060);
    $display("test transmit flags done");
    wr(uff_pkg::OFS_CTRL, 32'h0000_0041);
    i_uff_line_model.send({1'h1, 1'h0, 8'h11});
    i_uff_line_model.send({1'h0, 1'h1, 8'h22});
    i_uff_line_model.send({1'h0, 1'h0, 8'h33});
    i_uff_line_model.send({1'h0, 1'h0, 8'h44});
    rdc(uff_pkg::OFS_COUNT, 32'h0000_0004);
    rdc(uff_pkg::OFS_STATUS, 32'h0000_006A);
    rdc(uff_pkg::OFS_RXDATA, 32'h0000_0011);
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0066);
    @(posedge i_sys_clk);
    i_dma_rx_rd <= 1'h1;
    @(posedge i_sys_clk);
    i_dma_rx_rd <= 1'h0;
    #1 chk({24'h00_0000, o_dma_rx_data}, 32'h0000_0022);
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0060);
    wr(uff_pkg::OFS_STATUS, 32'h0000_0000);
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0060);
    $display("test receive flags done");
    wr(uff_pkg::OFS_IRQ_EN, 32'h0000_0004);
    i_uff_line_model.line(1'h0, 5);
    i_uff_line_model.send({1'h1, 1'h0, 8'h00});
    i_uff_line_model.line(1'h0, 30);
    i_uff_line_model.send({1'h1, 1'h0, 8'h00});
    i_uff_line_model.line(1'h1, 5);
    rdc(uff_pkg::OFS_COUNT, 32'h0000_0003);
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0070);
    chk({31'h0000_0000, o_irq}, 32'h0000_0001);
    wr(uff_pkg::OFS_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge i_sys_clk);
    chk({31'h0000_0000, o_irq}, 32'h0000_0000);
    wr(uff_pkg::OFS_IRQ_EN, 32'h0000_0004);
    wr(uff_pkg::OFS_IRQ_CLR, 32'h0000_0004);
    repeat (2) @(posedge i_sys_clk);
    chk({31'h0000_0000, o_irq}, 32'h0000_0000);
    wr(uff_pkg::OFS_STATUS, 32'h0000_FFFF);
    wr(uff_pkg::OFS_STATUS, 32'h0000_0000);
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0070);
    wr(uff_pkg::OFS_STATUS, 32'h0000_0000);
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0060);
    i_uff_line_model.send({1'h0, 1'h0, 8'h00});
    rdc(uff_pkg::OFS_COUNT, 32'h0000_0004);
    rdc(uff_pkg::OFS_STATUS, 32'h0000_0062);
    $display("test break and interrupt done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

// ---- verif/uff_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module uff_checker #(
  parameter int unsigned P_BREAK_CYCLES = 20
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_tx_take,
  input wire logic o_tx_avail,
  input wire logic [7:0] o_tx_byte,
  input wire logic i_dma_tx_wr,
  input wire logic i_dma_rx_rd,
  input wire logic [7:0] o_dma_rx_data,
  input wire logic o_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  write_answer_a: assert property (
    i_awvalid && o_awready && i_wvalid && o_wready |=> !o_awready && !o_wready ##1 o_bvalid)
    else $error("write response not on time");
  resp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("read data not on time");
  read_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  push_fills_a: assert property (i_dma_tx_wr |=> o_tx_avail)
    else $error("pushed byte not held");
  empty_stays_a: assert property (
    !o_tx_avail && !i_dma_tx_wr && o_wready |=> !o_tx_avail)
    else $error("empty transmit queue filled itself");
  tx_byte_hold_a: assert property (!i_tx_take |=> $stable(o_tx_byte))
    else $error("transmit byte changed without take");
  rx_byte_hold_a: assert property (
    !i_dma_rx_rd && !i_arvalid && !o_rvalid |=> $stable(o_dma_rx_data))
    else $error("receive byte changed without pop");
  irq_sticky_a: assert property (
    o_irq && !i_awvalid && o_awready && $past(o_awready) |=> o_irq)
    else $error("interrupt fell without a write");
endmodule : uff_checker
bind uff_top uff_checker #(.P_BREAK_CYCLES(P_BREAK_CYCLES)) i_uff_checker (.*);
`default_nettype wire

// ---- verif/uff_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module uff_line_model (
  input wire logic i_sys_clk,
  input wire logic i_tx_avail,
  output logic o_tx_take,
  output logic o_last_bit,
  output logic o_rx_valid,
  output uff_pkg::uff_rx_entry_t o_rx_entry,
  output logic o_rx_pin
);
  // ----------------------------------------
  // Line side stimulus
  // ----------------------------------------
  initial begin
    o_tx_take = 1'h0;
    o_last_bit = 1'h0;
    o_rx_valid = 1'h0;
    o_rx_entry = 10'h000;
    o_rx_pin = 1'h1;
  end
  // A take is only offered while the queue holds data.
  task automatic take(input int cnt);
    for (int k = 0; k < cnt; k++) begin
      @(posedge i_sys_clk);
      o_tx_take <= i_tx_avail;
      @(posedge i_sys_clk);
      o_tx_take <= 1'h0;
    end
  endtask : take
  task automatic last_bit();
    @(posedge i_sys_clk);
    o_last_bit <= 1'h1;
    @(posedge i_sys_clk);
    o_last_bit <= 1'h0;
  endtask : last_bit
  // The entry bus is scrambled once the strobe is gone.
  task automatic send(input uff_pkg::uff_rx_entry_t e);
    @(posedge i_sys_clk);
    o_rx_valid <= 1'h1;
    o_rx_entry <= e;
    @(posedge i_sys_clk);
    o_rx_valid <= 1'h0;
    o_rx_entry <= ~e;
  endtask : send
  task automatic line(input logic lvl, input int cyc);
    @(posedge i_sys_clk);
    o_rx_pin <= lvl;
    repeat (cyc) @(posedge i_sys_clk);
  endtask : line
endmodule : uff_line_model
`default_nettype wire
